// [rtl/trig_seq_pkg.sv]
// Purpose: shared constants and types of the line trigger sequencer
// Assumes: 32-bit classic Wishbone, 250 MHz mclk
// Notes: field layouts are carried by the packed structs below
package trig_seq_pkg;
	// ***********************************************************
	// sizes and timing
	// ***********************************************************
	localparam int NUM_BLOCKS = 31;
	localparam int NUM_SLOTS = 63;
	localparam int NUM_CONDS = 8;
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int TX_HALF = 100;
	localparam logic [4:0] FIRST_BLOCK = 5'h01;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	// ***********************************************************
	// register byte offsets
	// ***********************************************************
	localparam logic [9:0] OFS_CTRL = 10'h000;
	localparam logic [9:0] OFS_STATUS = 10'h004;
	localparam logic [9:0] OFS_THRESH = 10'h008;
	localparam logic [9:0] OFS_BUFCHAR = 10'h00c;
	localparam logic [9:0] OFS_TX = 10'h010;
	localparam logic [9:0] OFS_WAIT = 10'h014;
	localparam logic [9:0] OFS_POS = 10'h018;
	localparam logic [9:0] OFS_COND = 10'h040;
	localparam logic [9:0] OFS_SLOT = 10'h100;
	// ***********************************************************
	// control, transmit, buffer and status field positions
	// ***********************************************************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_SRC = 2;
	localparam int CTRL_MODE = 3;
	localparam int CTRL_PROTO = 5;
	localparam int CTRL_CODE = 7;
	localparam int CTRL_PAREN = 9;
	localparam int CTRL_PARODD = 10;
	localparam int TX_ENDF = 8;
	localparam int TX_LEAD = 9;
	localparam int TX_LIDX = 10;
	localparam int TX_LLVL = 13;
	localparam int BUF_PAR = 8;
	localparam int STAT_RUN = 5;
	localparam int STAT_LEFT = 6;
	localparam int STAT_HIT = 12;
	localparam int STAT_TXB = 15;
	localparam int STAT_TMR = 16;
	// ***********************************************************
	// enumerations
	// ***********************************************************
	typedef enum logic [1:0] {MODE_MON = 2'b00, MODE_DTE = 2'b01, MODE_DCE = 2'b10,
		MODE_RSV = 2'b11} mode_type;
	typedef enum logic [1:0] {PR_ASYNC = 2'b00, PR_SYNC = 2'b01, PR_BIT = 2'b10,
		PR_RSV = 2'b11} proto_type;
	typedef enum logic [2:0] {K_STRING = 3'b000, K_LEAD = 3'b001, K_TIMER = 3'b010,
		K_PARITY = 3'b011, K_BLKCHK = 3'b100, K_FCS = 3'b101, K_ABORT = 3'b110,
		K_FRAMING = 3'b111} kind_type;
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} seq_type;
	// ***********************************************************
	// carriers
	// ***********************************************************
	typedef struct packed {
		logic first; logic pval; logic pcare; logic neg;
		logic [7:0] care; logic [7:0] val;
	} slot_type;
	typedef struct packed {
		logic spare; logic hl; logic beep; logic tstop; logic tstart; logic en; logic level;
		logic [5:0] len; logic [5:0] first; kind_type kind; logic [4:0] target;
		logic [4:0] owner;
	} cond_type;
endpackage : trig_seq_pkg

// [rtl/line_trigger_sequencer.sv]
// Purpose: block-structured trigger sequencer of a serial line analyser
// Assumes: line clock, data, leads and error lines are asynchronous to mclk
// Notes: live chars are clocked in on the line clock rising edge, lsb first
// Operation
// - up to 31 numbered blocks as branch targets
// - 63 trigger slots compared in parallel
// - each string char uses one trigger; count left
// - timer conditions use no trigger resource
// - satisfied condition branches to its target block
// - stay in block until a condition fires
// - scan resumes right after the matched data
// - timer, beep, highlight act at trigger point
// - unused upper code bits are ignored
// - per-bit care mask on every pattern char
// - negated char matches anything but its value
// - no flags or check chars auto-appended
// - fcs and abort triggers only in bit protocol
// - parity ignored unless explicitly programmed
// - parity error triggers only in char protocol
// - error kinds gated by protocol, parity also by its enable
// - monitoring drives nothing onto the line
// - simulation supplies terminal or modem clocks
// - bit protocol end-frame action sends the fcs
// - wait delays later sends and lead sets
// - run on live line or buffered data
// - concurrent conditions, first listed wins
// - a match disables all other conditions
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module line_trigger_sequencer import trig_seq_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	// clock, enable, reset
	input wire logic mclk,
	input wire logic ce,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [9:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// observed line
	input wire logic line_clk,
	input wire logic line_data,
	input wire logic [7:0] lead_in,
	input wire logic [3:0] line_err,
	// driven line
	output logic tx_data,
	output logic tx_data_oe,
	output logic [7:0] lead_out,
	output logic lead_oe,
	output logic etc_out,
	output logic tc_out,
	output logic rc_out,
	// trigger events
	output logic trig,
	output logic beep,
	output logic highlight
);
	// ***********************************************************
	// state
	// ***********************************************************
	localparam int EXT_W = 14;
	localparam int LC_BIT = 8;
	localparam int RD_BIT = 9;
	localparam int ERR_BIT = 10;

	typedef struct packed {
		logic ack; logic [31:0] dat;                     // bus answer
		seq_type seq; logic [4:0] blk; logic [2:0] hit;  // sequencer
		logic src_buf; mode_type mode; proto_type proto; // configuration
		logic [1:0] code; logic par_en; logic par_odd;
		logic [15:0] thr;                                // timer threshold
		logic [NUM_CONDS-1:0][31:0] conds;               // condition table
		logic [NUM_SLOTS-1:0][19:0] slots;               // pattern slots
		logic [NUM_SLOTS-1:0] part;                      // partial matches
		logic [15:0] pos;                                // scan pointer
		logic [15:0] timer; logic tmr_run; logic [17:0] ms_cnt;
		logic [2:0][EXT_W-1:0] sy; logic [EXT_W-1:0] st; // input filters
		logic [8:0] rx_sh; logic [3:0] rx_cnt;
		logic [8:0] bchar; logic bstb;                   // buffered char
		logic [13:0] txp; logic txp_v;                   // pending action
		logic [15:0] wait_ms; logic [17:0] wait_cnt;
		logic [7:0] div; logic txclk;
		logic [15:0] tx_sh; logic [4:0] tx_cnt; logic tx_fcs; logic [15:0] crc;
		logic txd; logic [7:0] lead_o; logic etc; logic tc; logic rc;
		logic trig; logic beep; logic hl; logic oe;      // events, line drive enable
	} st_type;

	st_type s; // registered state
	st_type n; // next state

	// ***********************************************************
	// functions
	// ***********************************************************
	// byte-lane merge of a bus write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// one pattern char against one received char
	function automatic logic char_hit(input slot_type p, input logic [8:0] ch,
		input logic [1:0] code);
		logic [7:0] care;
		logic eq;
		care = p.care & (8'hff >> (2'd3 - code));
		eq = (((p.val ^ ch[7:0]) & care) == 8'h00) && (!p.pcare || (p.pval == ch[8]));
		return eq ^ p.neg;
	endfunction : char_hit

	// one crc-16 step over one sent bit
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction : crc_step

	// ***********************************************************
	// combinational next state
	// ***********************************************************
	logic [EXT_W-1:0] chg;
	logic [EXT_W-1:0] newst;
	logic [NUM_SLOTS-1:0] part_n;
	logic [3:0] nbits;
	logic [8:0] rch;
	logic ch_stb;
	logic [8:0] ch;
	logic par_err;
	logic [6:0] used;
	logic fire;
	logic [2:0] fidx;
	logic req;
	logic [9:0] a;
	logic [31:0] rd;
	logic ms_tick;
	logic tx_tick;
	cond_type c;
	slot_type p;

	always_comb begin
		n = s;
		chg = '0;
		newst = '0;
		part_n = '0;
		nbits = 4'h0;
		rch = 9'h000;
		ch_stb = 1'b0;
		ch = 9'h000;
		par_err = 1'b0;
		used = 7'h00;
		fire = 1'b0;
		fidx = 3'h0;
		req = 1'b0;
		a = 10'h000;
		rd = 32'h0000_0000;
		ms_tick = 1'b0;
		tx_tick = 1'b0;
		c = '0;
		p = '0;
		n.ack = 1'b0;
		n.bstb = 1'b0;
		n.trig = 1'b0;
		n.beep = 1'b0;
		n.hl = 1'b0;

		// three-stage filter: a change counts once stages two and three agree
		n.sy = {s.sy[1:0], {line_err, line_data, line_clk, lead_in}};
		for (int i = 0; i < EXT_W; i++) begin
			newst[i] = (s.sy[1][i] == s.sy[2][i]) ? s.sy[2][i] : s.st[i];
			chg[i] = newst[i] != s.st[i];
		end
		n.st = newst;

		// live deserialiser on the filtered line clock rising edge
		nbits = {2'b00, s.code} + 4'h5 + {3'b000, s.par_en};
		if (chg[LC_BIT] && newst[LC_BIT]) begin
			n.rx_sh = {s.st[RD_BIT], s.rx_sh[8:1]};
			n.rx_cnt = s.rx_cnt + 4'h1;
			if (s.rx_cnt + 4'h1 == nbits) begin
				n.rx_cnt = 4'h0;
				rch = n.rx_sh >> (4'h9 - nbits);
				if (!s.src_buf) begin
					ch_stb = 1'b1;
				end
			end
		end
		if (ch_stb) begin
			ch = s.par_en ? {rch[nbits-4'h1], rch[7:0] & (8'hff >> (4'h9 - nbits))} : rch;
		end
		// buffered chars replace live ones while replaying
		if (s.bstb && s.src_buf) begin
			ch_stb = 1'b1;
			ch = s.bchar;
		end
		par_err = s.par_en && ((^ch) != s.par_odd);

		// parallel slot compare; a string only grows on consecutive chars
		for (int i = 0; i < NUM_SLOTS; i++) begin
			p = slot_type'(s.slots[i]);
			part_n[i] = char_hit(p, ch, s.code) && (p.first || (i > 0 && s.part[i-1]));
		end
		if (ch_stb) begin
			n.part = part_n;
			n.pos = s.pos + 16'h0001;
		end

		// trigger resources used by enabled strings only
		for (int k = 0; k < NUM_CONDS; k++) begin
			c = cond_type'(s.conds[k]);
			if (c.en && c.kind == K_STRING) begin
				used = used + {1'b0, c.len};
			end
		end

		// condition evaluation; lowest index wins
		for (int k = NUM_CONDS - 1; k >= 0; k--) begin
			c = cond_type'(s.conds[k]);
			if (c.en && c.owner == s.blk && s.seq == ST_RUN) begin
				unique case (c.kind)
					K_STRING: if (ch_stb && c.len != 6'h00 && part_n[c.first + c.len - 6'h01]) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_LEAD: if (chg[c.len[2:0]] && newst[c.len[2:0]] == c.level) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_TIMER: if (s.timer > s.thr) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_PARITY: if (ch_stb && par_err && s.proto != PR_BIT) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_BLKCHK: if (chg[ERR_BIT] && newst[ERR_BIT] && s.proto != PR_BIT) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_FCS: if (chg[ERR_BIT+1] && newst[ERR_BIT+1] && s.proto == PR_BIT) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_ABORT: if (chg[ERR_BIT+2] && newst[ERR_BIT+2] && s.proto == PR_BIT) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
					K_FRAMING: if (chg[ERR_BIT+3] && newst[ERR_BIT+3] && s.proto == PR_ASYNC) begin
						fire = 1'b1;
						fidx = 3'(k);
					end
				endcase
			end
		end

		// branch on a match, otherwise hold the block
		if (fire) begin
			c = cond_type'(s.conds[fidx]);
			n.hit = fidx;
			n.blk = c.target;
			n.part = '0;
			n.trig = 1'b1;
			n.beep = c.beep;
			n.hl = c.hl;
			if (c.tstart) begin
				n.tmr_run = 1'b1;
			end
			if (c.tstop) begin
				n.tmr_run = 1'b0;
			end
			if (c.target == 5'h00) begin
				n.seq = ST_IDLE;
			end
		end

		// millisecond timer, saturating at its top
		ms_tick = s.ms_cnt == 18'(MS_CYCLES - 1);
		n.ms_cnt = ms_tick ? 18'h00000 : s.ms_cnt + 18'h00001;
		if (ms_tick && s.tmr_run && s.timer != 16'hffff) begin
			n.timer = s.timer + 16'h0001;
		end

		// wait countdown holds back pending sends and lead sets
		if (ms_tick && s.wait_ms != 16'h0000) begin
			n.wait_ms = s.wait_ms - 16'h0001;
		end

		// simulation clock divider; bits change on the falling edge
		n.div = (s.div == 8'(TX_HALF - 1)) ? 8'h00 : s.div + 8'h01;
		if (s.div == 8'(TX_HALF - 1)) begin
			n.txclk = ~s.txclk;
			tx_tick = s.txclk;
		end
		// a clock only starts on a divider rising edge, so no runt pulse follows a mode write
		n.etc = n.txclk && s.mode == MODE_DTE && (s.etc || !s.txclk);
		n.tc = n.txclk && s.mode == MODE_DCE && (s.tc || !s.txclk);
		n.rc = n.txclk && s.mode == MODE_DCE && (s.rc || !s.txclk);
		if (tx_tick && s.tx_cnt != 5'h00) begin
			n.txd = s.tx_sh[0];
			n.tx_sh = {1'b0, s.tx_sh[15:1]};
			n.tx_cnt = s.tx_cnt - 5'h01;
			if (s.proto == PR_BIT && !s.tx_fcs) begin
				n.crc = crc_step(s.crc, s.tx_sh[0]);
			end
		end
		// start the pending action once wait and shifter are done
		if (s.txp_v && s.wait_ms == 16'h0000 && s.tx_cnt == 5'h00 && s.oe) begin
			n.txp_v = 1'b0;
			if (s.txp[TX_LEAD]) begin
				n.lead_o[s.txp[TX_LIDX +: 3]] = s.txp[TX_LLVL];
			end else if (s.txp[TX_ENDF] && s.proto == PR_BIT) begin
				n.tx_sh = ~s.crc;
				n.tx_cnt = 5'h10;
				n.tx_fcs = 1'b1;
				n.crc = CRC_INIT;
			end else begin
				n.tx_sh = {8'h00, s.txp[7:0]};
				n.tx_cnt = {1'b0, nbits};
				n.tx_fcs = 1'b0;
			end
		end

		// wishbone classic slave, one wait state, ack for one cycle
		req = wb_cyc && wb_stb && !s.ack;
		a = {wb_adr[9:2], 2'b00};
		if (a >= OFS_SLOT && a < OFS_SLOT + 10'(4 * NUM_SLOTS)) begin
			rd = {12'h000, s.slots[a[7:2] - 6'h00]};
		end else if (a >= OFS_COND && a < OFS_COND + 10'(4 * NUM_CONDS)) begin
			rd = s.conds[a[4:2]];
		end else begin
			unique case (a)
				OFS_CTRL: rd = {21'h000000, s.par_odd, s.par_en, s.code, s.proto, s.mode,
					s.src_buf, 2'b00};
				OFS_STATUS: begin
					rd[4:0] = s.blk;
					rd[STAT_RUN] = s.seq == ST_RUN;
					rd[STAT_LEFT +: 6] = 6'(7'(NUM_SLOTS) - used);
					rd[STAT_HIT +: 3] = s.hit;
					rd[STAT_TXB] = s.txp_v || s.tx_cnt != 5'h00;
					rd[STAT_TMR +: 16] = s.timer;
				end
				OFS_THRESH: rd = {16'h0000, s.thr};
				OFS_WAIT: rd = {16'h0000, s.wait_ms};
				OFS_POS: rd = {16'h0000, s.pos};
				default: rd = 32'h0000_0000;
			endcase
		end
		if (req) begin
			n.ack = 1'b1;
			n.dat = wb_we ? 32'h0000_0000 : rd;
		end
		if (req && wb_we) begin
			if (a >= OFS_SLOT && a < OFS_SLOT + 10'(4 * NUM_SLOTS)) begin
				n.slots[a[7:2] - 6'h00] = 20'(merge({12'h000, s.slots[a[7:2] - 6'h00]},
					wb_dat_w, wb_sel));
			end else if (a >= OFS_COND && a < OFS_COND + 10'(4 * NUM_CONDS)) begin
				n.conds[a[4:2]] = merge(s.conds[a[4:2]], wb_dat_w, wb_sel);
			end else begin
				unique case (a)
					OFS_CTRL: if (wb_sel[0] && wb_sel[1]) begin
						n.src_buf = wb_dat_w[CTRL_SRC];
						n.mode = mode_type'(wb_dat_w[CTRL_MODE +: 2]);
						n.proto = proto_type'(wb_dat_w[CTRL_PROTO +: 2]);
						n.code = wb_dat_w[CTRL_CODE +: 2];
						n.par_en = wb_dat_w[CTRL_PAREN];
						n.par_odd = wb_dat_w[CTRL_PARODD];
						if (wb_dat_w[CTRL_STOP]) begin
							n.seq = ST_IDLE;
						end
						if (wb_dat_w[CTRL_RUN]) begin
							n.seq = ST_RUN;
							n.blk = FIRST_BLOCK;
							n.part = '0;
							n.pos = 16'h0000;
							n.timer = 16'h0000;
							n.tmr_run = 1'b0;
						end
					end
					OFS_THRESH: n.thr = 16'(merge({16'h0000, s.thr}, wb_dat_w, wb_sel));
					OFS_BUFCHAR: begin
						n.bchar = wb_dat_w[8:0];
						n.bstb = 1'b1;
					end
					OFS_TX: begin
						n.txp = wb_dat_w[13:0];
						n.txp_v = 1'b1;
					end
					OFS_WAIT: n.wait_ms = wb_dat_w[15:0];
					default: n.dat = 32'h0000_0000;
				endcase
			end
		end
		// drive enable follows the mode in the same edge, reserved mode drives nothing
		n.oe = n.mode == MODE_DTE || n.mode == MODE_DCE;
	end

	// ***********************************************************
	// state register
	// ***********************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	// ***********************************************************
	// outputs, all from flip-flops
	// ***********************************************************
	assign wb_dat_r = s.dat;
	assign wb_ack = s.ack;
	assign tx_data = s.txd;
	assign tx_data_oe = s.oe;
	assign lead_out = s.lead_o;
	assign lead_oe = s.oe;
	assign etc_out = s.etc;
	assign tc_out = s.tc;
	assign rc_out = s.rc;
	assign trig = s.trig;
	assign beep = s.beep;
	assign highlight = s.hl;
endmodule : line_trigger_sequencer

// [bench/seq_properties.sv]
// Purpose: bus, line and generated-clock properties of the trigger sequencer
// Assumes: one mclk domain, rst synchronous and active high
// Notes: bound onto every sequencer instance, sees its ports only
`timescale 1ns/1ns
module seq_props (
	// clock and reset
	input wire logic mclk,
	input wire logic ce,
	input wire logic rst,
	// bus handshake
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_ack,
	// line drivers
	input wire logic tx_data_oe,
	input wire logic lead_oe,
	input wire logic [7:0] lead_out,
	input wire logic etc_out,
	input wire logic tc_out,
	input wire logic rc_out,
	// trigger events
	input wire logic trig,
	input wire logic beep,
	input wire logic highlight
);
	// ***********************************************************
	// one domain: clock and reset given once
	// ***********************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_ack_take;
		wb_cyc && wb_stb && !wb_ack && ce |=> wb_ack;
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("request not answered next cycle");
	property p_ack_one;
		wb_ack |=> !wb_ack;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack stood longer than one cycle");
	property p_mon_quiet;
		!tx_data_oe |=> $stable(lead_out);
	endproperty
	a_mon_quiet: assert property (p_mon_quiet) else $error("leads moved while observing");
	// two cycles of grace: the clock registers follow the mode one edge late
	property p_mon_clk;
		!lead_oe [*2] |-> !etc_out && !tc_out && !rc_out;
	endproperty
	a_mon_clk: assert property (p_mon_clk) else $error("clock driven while observing");
	property p_clk_excl;
		etc_out |-> !tc_out && !rc_out;
	endproperty
	a_clk_excl: assert property (p_clk_excl) else $error("terminal and modem clocks mixed");
	property p_etc_hold;
		$rose(etc_out) |-> (etc_out || !lead_oe) [*8];
	endproperty
	a_etc_hold: assert property (p_etc_hold) else $error("terminal clock half period short");
	property p_tc_hold;
		$rose(tc_out) |-> ##1 (tc_out || !lead_oe) [*8];
	endproperty
	a_tc_hold: assert property (p_tc_hold) else $error("modem clock half period short");
	property p_beep_trig;
		beep |-> trig;
	endproperty
	a_beep_trig: assert property (p_beep_trig) else $error("alert without a trigger");
	property p_hl_trig;
		highlight |-> trig;
	endproperty
	a_hl_trig: assert property (p_hl_trig) else $error("highlight without a trigger");
endmodule : seq_props
bind line_trigger_sequencer seq_props chk_u (.mclk(mclk), .ce(ce), .rst(rst), .wb_cyc(wb_cyc),
	.wb_stb(wb_stb), .wb_ack(wb_ack), .tx_data_oe(tx_data_oe), .lead_oe(lead_oe),
	.lead_out(lead_out),
	.etc_out(etc_out), .tc_out(tc_out), .rc_out(rc_out), .trig(trig), .beep(beep),
	.highlight(highlight));

// [bench/line_far_end.sv]
// Purpose: far-side line unit sending characters to the observer
// Assumes: clock idles low, data taken on its rising edge, 160 ns per bit
// Notes: the clock stands still between frames
`timescale 1ns/1ns
module line_far_end (
	// serial line
	output logic line_clk,
	output logic line_data
);
	initial begin
		line_clk = 1'b0;
		line_data = 1'b0;
	end
	// one character, lsb first, data changes while the clock is low
	task automatic send_char(input logic [7:0] c);
		for (int i = 0; i < 8; i++) begin
			line_data = c[i];
			#80 line_clk = 1'b1;
			#80 line_clk = 1'b0;
		end
		// released line shows the inverse, so a stale bit never passes for data
		line_data = ~c[7];
	endtask : send_char
endmodule : line_far_end

// [bench/tb_top.sv]
// Purpose: self-checking bench of the line trigger sequencer
// Assumes: 250 MHz mclk, link clock from the far-end model
// Notes: expected triggers come from a small reference model below
`timescale 1ns/1ns
module tb_top import trig_seq_pkg::*; ;
	logic mclk = 1'b0, ce = 1'b1, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [9:0] wb_adr = 10'h000;
	logic [3:0] wb_sel = 4'hf;
	logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
	logic [7:0] lead_in = 8'h00, lead_out;
	logic [3:0] line_err = 4'h0;
	logic wb_ack, line_clk, line_data, tx_data, tx_data_oe, lead_oe, etc_out, tc_out, rc_out;
	logic trig, beep, highlight, etc_q, tc_q;
	logic [7:0] rnd = 8'h45; // lfsr start, 69
	int num_errors = 0, checked = 0, cyc_cnt = 0, trig_cnt = 0, beep_cnt = 0;
	int etc_cnt = 0, tc_cnt = 0, exp_trig = 0;
	always #2 mclk = ~mclk;
	line_far_end far_u (.line_clk(line_clk), .line_data(line_data));
	line_trigger_sequencer #(.MS_CYCLES(10)) dut_u (.mclk(mclk), .ce(ce), .rst(rst),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .line_clk(line_clk),
		.line_data(line_data), .lead_in(lead_in), .line_err(line_err), .tx_data(tx_data),
		.tx_data_oe(tx_data_oe), .lead_out(lead_out), .lead_oe(lead_oe), .etc_out(etc_out),
		.tc_out(tc_out), .rc_out(rc_out), .trig(trig), .beep(beep), .highlight(highlight));
	// ***********************************************************
	// event counters and hang guard
	// ***********************************************************
	always @(posedge mclk) begin
		etc_q <= etc_out;
		tc_q <= tc_out;
		if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
		if (beep === 1'b1 && highlight === 1'b1) beep_cnt <= beep_cnt + 1;
		if (etc_out === 1'b1 && etc_q === 1'b0) etc_cnt <= etc_cnt + 1;
		if (tc_out === 1'b1 && tc_q === 1'b0) tc_cnt <= tc_cnt + 1;
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 30000) begin
			num_errors = num_errors + 1;
			summarize();
		end
	end
	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [31:0] ctrl_w(input logic run, input logic src, input mode_type m,
		input logic [1:0] code, input logic par);
		return {22'h0, par, code, PR_SYNC, m, src, 1'b0, run};
	endfunction : ctrl_w
	// every condition also asks for alert and highlight
	function automatic logic [31:0] cond_w(input logic [4:0] own, input logic [4:0] tgt,
		input kind_type k, input logic [5:0] first, input logic [5:0] len);
		return cond_type'{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, len, first, k, tgt, own};
	endfunction : cond_w
	task automatic summarize();
		if (num_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// classic single cycle, held until ack is sampled high, released at that edge
	task automatic wb_xfer(input logic [9:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat_w <= d;
		do @(posedge mclk); while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_xfer
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(a, 1'b1, d, q);
	endtask : wr
	task automatic feed(input logic [7:0] c, input logic p);
		wr(OFS_BUFCHAR, {23'h0, p, c});
		repeat (4) @(posedge mclk);
	endtask : feed
	// ***********************************************************
	// scenarios
	// ***********************************************************
	initial begin
		logic [31:0] q;
		logic [7:0] v, care, c;
		logic [7:0] s_q[$];
		logic neg, pc, pv, p, hit;
		logic [1:0] code;
		int st;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk(q[11:6], 63);
		chk(tx_data_oe, 1'b0);
		wb_xfer(10'h3fc, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		// block 1: string "ab" branches to block 2; a timer condition in block 5
		wr(OFS_SLOT, {12'h0, slot_type'{1'b1, 1'b0, 1'b0, 1'b0, 8'hff, 8'h61}});
		wr(OFS_SLOT + 10'h004, {12'h0, slot_type'{1'b0, 1'b0, 1'b0, 1'b0, 8'hff, 8'h62}});
		wr(OFS_COND, cond_w(5'h01, 5'h02, K_STRING, 6'h00, 6'h02));
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk(q[11:6], 61);
		wr(OFS_COND + 10'h004, cond_w(5'h05, 5'h01, K_TIMER, 6'h00, 6'h05));
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk(q[11:6], 61);
		wr(OFS_CTRL, ctrl_w(1'b1, 1'b1, MODE_MON, 2'h3, 1'b0));
		s_q = '{8'h61, 8'h78, 8'h62, 8'h61, 8'h62};
		st = 0;
		foreach (s_q[i]) begin
			feed(s_q[i], 1'b0);
			if (st == 1 && s_q[i] == 8'h62) begin
				exp_trig++;
				st = 0;
			end else begin
				st = (s_q[i] == 8'h61);
			end
		end
		chk(trig_cnt, exp_trig);
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk({q[14:12], q[4:0]}, 8'h02);
		wb_xfer(OFS_POS, 1'b0, 32'h0, q);
		chk(q, 5);
		// block 2: 16 random masked, negated, parity-qualified single characters
		wr(OFS_COND + 10'h008, cond_w(5'h02, 5'h02, K_STRING, 6'h02, 6'h01));
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			v = rnd;
			rnd = lfsr(rnd);
			care = rnd;
			{pv, pc, neg} = rnd[2:0];
			rnd = lfsr(rnd);
			c = rnd[7] ? v ^ (rnd & 8'he0) : rnd;
			p = rnd[0];
			code = rnd[2:1];
			wr(OFS_CTRL, ctrl_w(1'b0, 1'b1, MODE_MON, code, 1'b1));
			wr(OFS_SLOT + 10'h008, {12'h0, slot_type'{1'b1, pv, pc, neg, care, v}});
			feed(c, p);
			hit = ((((c ^ v) & care & (8'hff >> (3 - code))) == 8'h00) && (!pc || pv == p)) ^ neg;
			exp_trig += hit;
			chk(trig_cnt, exp_trig);
		end
		// lead 3 going high ends the run
		wr(OFS_COND + 10'h00c, cond_w(5'h02, 5'h00, K_LEAD, 6'h00, 6'h03));
		@(posedge mclk);
		lead_in <= 8'h08;
		repeat (20) @(posedge mclk);
		exp_trig++;
		chk(trig_cnt, exp_trig);
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk({q[14:12], q[5]}, 4'h6);
		// live line: a new run starts over in block 1
		wr(OFS_CTRL, ctrl_w(1'b1, 1'b0, MODE_MON, 2'h3, 1'b0));
		far_u.send_char(8'h7a);
		far_u.send_char(8'h61);
		far_u.send_char(8'h62);
		repeat (20) @(posedge mclk);
		exp_trig++;
		chk(trig_cnt, exp_trig);
		wb_xfer(OFS_STATUS, 1'b0, 32'h0, q);
		chk(q[5:0], 6'h22);
		chk(beep_cnt, exp_trig);
		// error kinds in a char protocol: fcs is ignored, block check is taken
		wr(OFS_COND + 10'h010, cond_w(5'h02, 5'h03, K_FCS, 6'h00, 6'h00));
		wr(OFS_COND + 10'h014, cond_w(5'h02, 5'h03, K_BLKCHK, 6'h00, 6'h00));
		line_err <= 4'h2;
		repeat (20) @(posedge mclk);
		chk(trig_cnt, exp_trig);
		line_err <= 4'h3;
		repeat (20) @(posedge mclk);
		exp_trig++;
		chk(trig_cnt, exp_trig);
		// terminal simulation supplies its clock and drives the line, the modem clock stays off
		wr(OFS_CTRL, ctrl_w(1'b0, 1'b0, MODE_DTE, 2'h3, 1'b0));
		repeat (450) @(posedge mclk);
		chk({tx_data_oe, etc_cnt >= 2, tc_cnt == 0}, 3'h7);
		// lead 3 set held back by a two millisecond wait, then one char sent
		wr(OFS_WAIT, 32'h0000_0002);
		wr(OFS_TX, 32'h0000_2e00);
		repeat (4) @(posedge mclk);
		chk(lead_out, 8'h00);
		repeat (30) @(posedge mclk);
		wr(OFS_TX, 32'h0000_00ff);
		repeat (250) @(posedge mclk);
		chk({tx_data, lead_out}, 9'h108);
		// pass through monitoring so the terminal clock may stop early
		wr(OFS_CTRL, ctrl_w(1'b0, 1'b0, MODE_MON, 2'h3, 1'b0));
		wr(OFS_CTRL, ctrl_w(1'b0, 1'b0, MODE_DCE, 2'h3, 1'b0));
		repeat (450) @(posedge mclk);
		chk({tc_cnt >= 2, rc_out === tc_out}, 2'h3);
		wr(OFS_CTRL, ctrl_w(1'b0, 1'b0, MODE_MON, 2'h3, 1'b0));
		repeat (4) @(posedge mclk);
		chk({tx_data_oe, lead_oe}, 2'h0);
		summarize();
	end
endmodule : tb_top
